/* fic_interleave_codec.sv */
`timescale 1ns/100ps
// Function
// - code only when correction enable is one
// - data field and crc both coded
// - rate half convolutional code, constraint four
// - two coded symbols per input bit
// - interleaving used exactly when coding enabled
// - both buffers are four by four
// - transmit writes rows, reads columns
// - receive writes columns, reads columns; row order restored on the decoded bits
// - coded air length multiple of two bytes
// - at least one termination byte appended when coded, none when uncoded
// - coded packets pad one or two bytes, even total
// - padding stripped before receive output
// - interleaver blocks at least two bytes
module fic_interleave_codec
    import fic_pkg::*;
#(
    parameter int TRACE_DEPTH = FIC_TRACE_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic modem_cfg_correction_enable,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic tx_sym,
    output logic tx_sym_valid,
    input wire logic tx_sym_ready,
    input wire logic rx_start,
    input wire logic [7:0] rx_len,
    input wire logic rx_sym,
    input wire logic rx_sym_valid,
    output logic rx_sym_ready,
    output logic [7:0] rx_data,
    output logic rx_data_valid,
    output logic rx_data_last
);

    localparam int FW = $clog2(TRACE_DEPTH);

    // reset release chain
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ---------------- transmit path ----------------
    fic_tx_state_type tx_state_reg, tx_state_next;
    logic [FIC_MAT_BITS-1:0] tx_mat_reg, tx_mat_next; // row-major matrix
    logic tx_slot_reg, tx_slot_next;                   // byte slot in block
    logic tx_coded_reg, tx_coded_next;                 // coding latched per packet
    logic tx_seen_reg, tx_seen_next;                   // last data byte taken
    logic [1:0] tx_pad_reg, tx_pad_next;               // pad bytes still owed
    logic [3:0] tx_pos_reg, tx_pos_next;               // read position
    logic tx_ph_reg, tx_ph_next;                       // symbol phase of bit
    logic tx_done_reg, tx_done_next;                   // last symbol presented
    logic tx_ready_reg, tx_ready_next;
    logic tx_sym_reg, tx_sym_next;
    logic tx_sym_valid_reg, tx_sym_valid_next;
    logic [7:0] tx_byte;
    logic tx_take_in;
    logic tx_take_pad;
    logic tx_bit;
    logic enc_clear;
    logic enc_adv;
    logic [1:0] enc_pair;

    // column-major read when coded, plain order otherwise
    assign tx_bit = tx_coded_reg ? tx_mat_reg[{tx_pos_reg[1:0], tx_pos_reg[3:2]}]
                                 : tx_mat_reg[tx_pos_reg];

    // encoder shared by every coded bit of the packet
    fic_conv_enc u_enc (
        .clk(clk),
        .rst_n(rst_n),
        .clear(enc_clear),
        .advance(enc_adv),
        .data_bit(tx_bit),
        .code_pair(enc_pair)
    );

    // transmit sequencer next state
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_mat_next = tx_mat_reg;
        tx_slot_next = tx_slot_reg;
        tx_coded_next = tx_coded_reg;
        tx_seen_next = tx_seen_reg;
        tx_pad_next = tx_pad_reg;
        tx_pos_next = tx_pos_reg;
        tx_ph_next = tx_ph_reg;
        tx_done_next = tx_done_reg;
        tx_ready_next = tx_ready_reg;
        tx_sym_next = tx_sym_reg;
        tx_sym_valid_next = tx_sym_valid_reg;
        enc_clear = 1'b0;
        enc_adv = 1'b0;
        tx_take_in = !tx_seen_reg && tx_valid && tx_ready_reg;
        tx_take_pad = tx_seen_reg && (tx_pad_reg != 2'h0);
        tx_byte = tx_take_pad ? FIC_PAD_BYTE : tx_data;
        case (tx_state_reg)
            FIC_TX_IDLE: begin
                // fresh trellis and fill position for each packet
                enc_clear = 1'b1;
                tx_coded_next = modem_cfg_correction_enable;
                tx_slot_next = 1'b0;
                tx_seen_next = 1'b0;
                tx_pad_next = 2'h0;
                tx_done_next = 1'b0;
                if (tx_valid) begin
                    tx_state_next = FIC_TX_LOAD;
                    tx_ready_next = 1'b1;
                end
            end
            FIC_TX_LOAD: begin
                // every byte incl. crc goes through the matrix rows
                if (tx_take_in || tx_take_pad) begin
                    for (int i = 0; i < 8; i++) begin
                        tx_mat_next[{tx_slot_reg, 3'(i)}] = tx_byte[7 - i];
                    end
                    if (tx_take_in && tx_last) begin
                        tx_seen_next = 1'b1;
                        // odd count gets one byte, even count two
                        if (tx_coded_reg) begin
                            tx_pad_next = tx_slot_reg ? FIC_PAD_EVEN : FIC_PAD_ODD;
                        end
                    end
                    if (tx_take_pad) begin
                        tx_pad_next = tx_pad_reg - 2'h1;
                    end
                    // coded blocks always hold two bytes
                    if (!tx_coded_reg || tx_slot_reg) begin
                        tx_state_next = FIC_TX_SEND;
                        tx_ready_next = 1'b0;
                        tx_pos_next = 4'h0;
                        tx_ph_next = 1'b0;
                        tx_slot_next = 1'b0;
                    end else begin
                        tx_slot_next = 1'b1;
                        tx_ready_next = !(tx_take_in && tx_last) && !tx_seen_reg;
                    end
                end
            end
            FIC_TX_SEND: begin
                if (!tx_sym_valid_reg || tx_sym_ready) begin
                    if (tx_done_reg) begin
                        // block gone: next block, or packet finished
                        tx_sym_valid_next = 1'b0;
                        tx_done_next = 1'b0;
                        if (tx_seen_reg && tx_pad_reg == 2'h0) begin
                            tx_state_next = FIC_TX_IDLE;
                        end else begin
                            tx_state_next = FIC_TX_LOAD;
                            tx_ready_next = !tx_seen_reg;
                        end
                    end else if (tx_coded_reg) begin
                        // two symbols per bit, history shifts after the second
                        tx_sym_valid_next = 1'b1;
                        tx_sym_next = tx_ph_reg ? enc_pair[1] : enc_pair[0];
                        enc_adv = tx_ph_reg;
                        tx_ph_next = !tx_ph_reg;
                        tx_pos_next = tx_ph_reg ? tx_pos_reg + 4'h1 : tx_pos_reg;
                        tx_done_next = tx_ph_reg && (tx_pos_reg == 4'hF);
                    end else begin
                        // uncoded byte passes straight, msb first
                        tx_sym_valid_next = 1'b1;
                        tx_sym_next = tx_bit;
                        tx_pos_next = tx_pos_reg + 4'h1;
                        tx_done_next = (tx_pos_reg == 4'h7);
                    end
                end
            end
            default: tx_state_next = FIC_TX_IDLE;
        endcase
    end

    // transmit registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg <= FIC_TX_IDLE;
            tx_mat_reg <= '0;
            tx_slot_reg <= 1'b0;
            tx_coded_reg <= 1'b0;
            tx_seen_reg <= 1'b0;
            tx_pad_reg <= 2'h0;
            tx_pos_reg <= 4'h0;
            tx_ph_reg <= 1'b0;
            tx_done_reg <= 1'b0;
            tx_ready_reg <= 1'b0;
            tx_sym_reg <= 1'b0;
            tx_sym_valid_reg <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_mat_reg <= tx_mat_next;
            tx_slot_reg <= tx_slot_next;
            tx_coded_reg <= tx_coded_next;
            tx_seen_reg <= tx_seen_next;
            tx_pad_reg <= tx_pad_next;
            tx_pos_reg <= tx_pos_next;
            tx_ph_reg <= tx_ph_next;
            tx_done_reg <= tx_done_next;
            tx_ready_reg <= tx_ready_next;
            tx_sym_reg <= tx_sym_next;
            tx_sym_valid_reg <= tx_sym_valid_next;
        end
    end

    assign tx_ready = tx_ready_reg;
    assign tx_sym = tx_sym_reg;
    assign tx_sym_valid = tx_sym_valid_reg;

    // ---------------- receive path ----------------
    fic_rx_state_type rx_state_reg, rx_state_next;
    logic [1:0] rx_mat_reg [FIC_MAT_BITS];             // symbol pairs
    logic [1:0] rx_mat_next [FIC_MAT_BITS];
    logic rx_coded_reg, rx_coded_next;
    logic [7:0] rx_len_reg, rx_len_next;               // bytes to deliver
    logic [11:0] rx_total_reg, rx_total_next;          // decoded bits incl. pad
    logic [4:0] rx_wpos_reg, rx_wpos_next;             // symbol fill position
    logic [3:0] rx_rpos_reg, rx_rpos_next;             // pair read position
    logic [11:0] rx_steps_reg, rx_steps_next;          // trellis steps done
    logic [11:0] rx_out_reg, rx_out_next;              // bits delivered
    logic [FW-1:0] rx_flush_reg, rx_flush_next;        // flush bit index
    logic [15:0] rx_byte_reg, rx_byte_next; // decoded block, packet order
    logic [3:0] rx_bpos; // buffer slot of the bit now leaving the trellis
    logic rx_bsel; // which byte of the block a completed byte is
    logic rx_bdone; // a whole byte now stands in the buffer
    logic [FIC_METRIC_W-1:0] met_reg [FIC_STATES];     // path metrics
    logic [FIC_METRIC_W-1:0] met_next [FIC_STATES];
    logic [TRACE_DEPTH-1:0] path_reg [FIC_STATES];     // survivor bits
    logic [TRACE_DEPTH-1:0] path_next [FIC_STATES];
    logic rx_sym_ready_reg, rx_sym_ready_next;
    logic [7:0] rx_data_reg, rx_data_next;
    logic rx_data_valid_reg, rx_data_valid_next;
    logic rx_data_last_reg, rx_data_last_next;
    logic [FIC_METRIC_W-1:0] acs_met [FIC_STATES];
    logic [TRACE_DEPTH-1:0] acs_path [FIC_STATES];
    logic [FIC_METRIC_W-1:0] cand0;
    logic [FIC_METRIC_W-1:0] cand1;
    logic [2:0] best_state;
    logic [1:0] dec_pair;
    logic emit_en;
    logic emit_bit;

    // wrap-safe metric compare: a not worse than b
    function automatic logic fic_le(input logic [FIC_METRIC_W-1:0] a, input logic [FIC_METRIC_W-1:0] b);
        logic [FIC_METRIC_W-1:0] d;
        d = a - b;
        return d[FIC_METRIC_W-1] || (d == '0);
    endfunction

    // hamming distance of two symbol pairs
    function automatic logic [FIC_METRIC_W-1:0] fic_dist(input logic [1:0] a, input logic [1:0] b);
        logic [1:0] x;
        x = a ^ b;
        return FIC_METRIC_W'({1'b0, x[1]} + {1'b0, x[0]});
    endfunction

    // the code runs in air order, so the trellis takes the pairs back in arrival order;
    // the row order is restored on the decoded bits below
    assign dec_pair = rx_mat_reg[{rx_rpos_reg[1:0], rx_rpos_reg[3:2]}];

    // add-compare-select over all eight states, and best state search
    always_comb begin
        cand0 = '0;
        cand1 = '0;
        for (int s = 0; s < FIC_STATES; s++) begin
            cand0 = met_reg[{1'b0, 2'(s >> 1)}] + fic_dist(dec_pair, fic_code_pair({1'b0, 2'(s >> 1), s[0]}));
            cand1 = met_reg[{1'b1, 2'(s >> 1)}] + fic_dist(dec_pair, fic_code_pair({1'b1, 2'(s >> 1), s[0]}));
            if (fic_le(cand0, cand1)) begin
                acs_met[s] = cand0;
                acs_path[s] = {path_reg[{1'b0, 2'(s >> 1)}][TRACE_DEPTH-2:0], s[0]};
            end else begin
                acs_met[s] = cand1;
                acs_path[s] = {path_reg[{1'b1, 2'(s >> 1)}][TRACE_DEPTH-2:0], s[0]};
            end
        end
        best_state = 3'h0;
        for (int s = 1; s < FIC_STATES; s++) begin
            if (!fic_le(met_reg[best_state], met_reg[s])) begin
                best_state = 3'(s);
            end
        end
    end

    // receive sequencer next state
    always_comb begin
        rx_state_next = rx_state_reg;
        rx_mat_next = rx_mat_reg;
        rx_coded_next = rx_coded_reg;
        rx_len_next = rx_len_reg;
        rx_total_next = rx_total_reg;
        rx_wpos_next = rx_wpos_reg;
        rx_rpos_next = rx_rpos_reg;
        rx_steps_next = rx_steps_reg;
        rx_out_next = rx_out_reg;
        rx_flush_next = rx_flush_reg;
        rx_byte_next = rx_byte_reg;
        met_next = met_reg;
        path_next = path_reg;
        rx_sym_ready_next = rx_sym_ready_reg;
        rx_data_next = rx_data_reg;
        rx_data_valid_next = 1'b0;
        rx_data_last_next = rx_data_last_reg;
        emit_en = 1'b0;
        emit_bit = 1'b0;
        case (rx_state_reg)
            FIC_RX_IDLE: begin
                rx_sym_ready_next = 1'b0;
                if (rx_start) begin
                    // new packet: trellis at start state, fill position zero
                    rx_coded_next = modem_cfg_correction_enable;
                    rx_len_next = rx_len;
                    rx_total_next = 12'(({4'h0, rx_len} + {10'h0, rx_len[0] ? FIC_PAD_ODD : FIC_PAD_EVEN}) << 3);
                    rx_wpos_next = 5'h00;
                    rx_rpos_next = 4'h0;
                    rx_steps_next = 12'h000;
                    rx_out_next = 12'h000;
                    for (int s = 0; s < FIC_STATES; s++) begin
                        met_next[s] = (s == 0) ? FIC_METRIC_START : FIC_METRIC_OTHER;
                        path_next[s] = '0;
                    end
                    rx_data_last_next = 1'b0;
                    rx_sym_ready_next = 1'b1;
                    rx_state_next = FIC_RX_FILL;
                end
            end
            FIC_RX_FILL: begin
                if (rx_sym_valid && rx_sym_ready_reg) begin
                    if (rx_coded_reg) begin
                        // pair k lands in row k mod 4, column k div 4
                        rx_mat_next[{rx_wpos_reg[2:1], rx_wpos_reg[4:3]}][rx_wpos_reg[0]] = rx_sym;
                        rx_wpos_next = rx_wpos_reg + 5'h01;
                        if (rx_wpos_reg == 5'h1F) begin
                            rx_sym_ready_next = 1'b0;
                            rx_rpos_next = 4'h0;
                            rx_state_next = FIC_RX_DEC;
                        end
                    end else begin
                        emit_en = 1'b1;
                        emit_bit = rx_sym;
                    end
                end
            end
            FIC_RX_DEC: begin
                // one trellis step per pair; oldest survivor bit leaves
                met_next = acs_met;
                path_next = acs_path;
                if (rx_steps_reg >= 12'(TRACE_DEPTH)) begin
                    emit_en = 1'b1;
                    emit_bit = path_reg[best_state][TRACE_DEPTH-1];
                end
                rx_steps_next = rx_steps_reg + 12'h001;
                rx_rpos_next = rx_rpos_reg + 4'h1;
                if (rx_rpos_reg == 4'hF) begin
                    if (rx_steps_next == rx_total_reg) begin
                        rx_flush_next = FW'(TRACE_DEPTH - 1);
                        rx_state_next = FIC_RX_FLUSH;
                    end else begin
                        rx_wpos_next = 5'h00;
                        rx_sym_ready_next = 1'b1;
                        rx_state_next = FIC_RX_FILL;
                    end
                end
            end
            FIC_RX_FLUSH: begin
                // termination reached: drain the best survivor
                emit_en = 1'b1;
                emit_bit = path_reg[best_state][rx_flush_reg];
                rx_flush_next = rx_flush_reg - FW'(1);
            end
            default: rx_state_next = FIC_RX_IDLE;
        endcase
        // coded bits leave in column order: put them back into rows, bytes read row by row
        rx_bpos = rx_coded_reg ? {rx_out_reg[1:0], rx_out_reg[3:2]} : rx_out_reg[3:0];
        rx_bsel = rx_coded_reg ? rx_out_reg[1] : rx_out_reg[3];
        rx_bdone = rx_coded_reg ? (rx_out_reg[3:2] == 2'h3 && rx_out_reg[0]) : (rx_out_reg[2:0] == 3'h7);
        // deliver bytes only up to the packet length; pad never leaves
        if (emit_en) begin
            rx_byte_next[rx_bpos] = emit_bit;
            rx_out_next = rx_out_reg + 12'h001;
            if (rx_bdone) begin
                for (int i = 0; i < 8; i++) begin
                    rx_data_next[7 - i] = rx_byte_next[{rx_bsel, 3'(i)}];
                end
                rx_data_valid_next = 1'b1;
                rx_data_last_next = ({rx_out_reg[11:4], rx_bsel} == ({1'b0, rx_len_reg} - 9'h001));
                if (rx_data_last_next) begin
                    rx_sym_ready_next = 1'b0;
                    rx_state_next = FIC_RX_IDLE;
                end
            end
        end
    end

    // receive registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg <= FIC_RX_IDLE;
            for (int i = 0; i < FIC_MAT_BITS; i++) begin
                rx_mat_reg[i] <= 2'h0;
            end
            for (int s = 0; s < FIC_STATES; s++) begin
                met_reg[s] <= FIC_METRIC_START;
                path_reg[s] <= '0;
            end
            rx_coded_reg <= 1'b0;
            rx_len_reg <= 8'h00;
            rx_total_reg <= 12'h000;
            rx_wpos_reg <= 5'h00;
            rx_rpos_reg <= 4'h0;
            rx_steps_reg <= 12'h000;
            rx_out_reg <= 12'h000;
            rx_flush_reg <= '0;
            rx_byte_reg <= 16'h0000;
            rx_sym_ready_reg <= 1'b0;
            rx_data_reg <= 8'h00;
            rx_data_valid_reg <= 1'b0;
            rx_data_last_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_mat_reg <= rx_mat_next;
            met_reg <= met_next;
            path_reg <= path_next;
            rx_coded_reg <= rx_coded_next;
            rx_len_reg <= rx_len_next;
            rx_total_reg <= rx_total_next;
            rx_wpos_reg <= rx_wpos_next;
            rx_rpos_reg <= rx_rpos_next;
            rx_steps_reg <= rx_steps_next;
            rx_out_reg <= rx_out_next;
            rx_flush_reg <= rx_flush_next;
            rx_byte_reg <= rx_byte_next;
            rx_sym_ready_reg <= rx_sym_ready_next;
            rx_data_reg <= rx_data_next;
            rx_data_valid_reg <= rx_data_valid_next;
            rx_data_last_reg <= rx_data_last_next;
        end
    end

    assign rx_sym_ready = rx_sym_ready_reg;
    assign rx_data = rx_data_reg;
    assign rx_data_valid = rx_data_valid_reg;
    assign rx_data_last = rx_data_last_reg;

endmodule

/* fic_pkg.sv */
// shared constants, types and helpers of the interleaving codec
package fic_pkg;

    // interleaver matrix geometry
    localparam int FIC_MAT_DIM = 4;
    localparam int FIC_MAT_BITS = FIC_MAT_DIM * FIC_MAT_DIM;

    // convolutional code: three history bits plus the current bit
    localparam int FIC_HIST_BITS = 3;
    localparam int FIC_STATES = 8;
    localparam logic [3:0] FIC_POLY_A = 4'hF;
    localparam logic [3:0] FIC_POLY_B = 4'hD;
    localparam logic [2:0] FIC_START_STATE = 3'h0;

    // decoder path memory and metrics
    localparam int FIC_TRACE_DEPTH = 16;
    localparam int FIC_METRIC_W = 6;
    localparam logic [FIC_METRIC_W-1:0] FIC_METRIC_START = 6'h00;
    localparam logic [FIC_METRIC_W-1:0] FIC_METRIC_OTHER = 6'h08;

    // termination padding
    localparam logic [1:0] FIC_PAD_ODD = 2'h1;
    localparam logic [1:0] FIC_PAD_EVEN = 2'h2;
    localparam logic [7:0] FIC_PAD_BYTE = 8'h00;

    // sequencer states
    typedef enum logic [1:0] {FIC_TX_IDLE, FIC_TX_LOAD, FIC_TX_SEND} fic_tx_state_type;
    typedef enum logic [1:0] {FIC_RX_IDLE, FIC_RX_FILL, FIC_RX_DEC, FIC_RX_FLUSH} fic_rx_state_type;

    // code pair for a window of {history, current bit}, newest bit in bit 0
    function automatic logic [1:0] fic_code_pair(input logic [3:0] win);
        return {^(win & FIC_POLY_B), ^(win & FIC_POLY_A)};
    endfunction

endpackage

/* fic_conv_enc.sv */
`timescale 1ns/100ps
// convolutional encoder history register
module fic_conv_enc
    import fic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic advance,
    input wire logic data_bit,
    output logic [1:0] code_pair
);

    logic [FIC_HIST_BITS-1:0] hist_reg; // last three coded input bits
    logic [FIC_HIST_BITS-1:0] hist_next;

    // next history: cleared per packet, shifted once per coded bit
    always_comb begin
        hist_next = hist_reg;
        if (clear) begin
            hist_next = FIC_START_STATE;
        end else if (advance) begin
            hist_next = {hist_reg[1:0], data_bit};
        end
    end

    // history register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_reg <= FIC_START_STATE;
        end else begin
            hist_reg <= hist_next;
        end
    end

    // two output bits from the current bit and the history
    assign code_pair = fic_code_pair({hist_reg, data_bit});

endmodule

/* fic_interleave_codec_chk.sv */
`timescale 1ns/100ps
// port checks of the codec handshakes and pulses
module fic_interleave_codec_chk #(parameter int TRACE_DEPTH = 16) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic modem_cfg_correction_enable,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic tx_sym,
    input wire logic tx_sym_valid,
    input wire logic tx_sym_ready,
    input wire logic rx_start,
    input wire logic rx_sym_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_data_valid,
    input wire logic rx_data_last
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // final byte of a packet taken
    sequence last_take_s; tx_valid && tx_ready && tx_last; endsequence
    // byte taken with coding off
    sequence plain_take_s; tx_valid && tx_ready && !modem_cfg_correction_enable; endsequence
    // final byte delivered
    sequence rx_end_s; rx_data_valid && rx_data_last; endsequence
    reset_idle_a: assert property ($rose(reset_n) |-> !tx_ready && !tx_sym_valid && !rx_sym_ready) else $error("busy after reset");
    sym_hold_a: assert property (tx_sym_valid && !tx_sym_ready |=> tx_sym_valid && $stable(tx_sym)) else $error("symbol dropped");
    last_stop_a: assert property (last_take_s |=> !tx_ready [*8]) else $error("byte taken after last");
    plain_byte_a: assert property (plain_take_s |=> !tx_ready [*8]) else $error("uncoded byte overlap");
    rx_pulse_a: assert property (rx_data_valid |=> !rx_data_valid) else $error("valid too long");
    rx_hold_a: assert property (!rx_data_valid |-> $stable(rx_data)) else $error("data moved");
    last_keep_a: assert property (rx_data_last && !rx_start |=> rx_data_last) else $error("last dropped");
    pad_skip_a: assert property (rx_end_s |=> !rx_sym_ready [*2]) else $error("pad symbols taken");
endmodule
bind fic_interleave_codec fic_interleave_codec_chk #(.TRACE_DEPTH(TRACE_DEPTH)) u_chk (.clk, .reset_n,
    .modem_cfg_correction_enable, .tx_valid, .tx_last, .tx_ready, .tx_sym, .tx_sym_valid, .tx_sym_ready,
    .rx_start, .rx_sym_ready, .rx_data, .rx_data_valid, .rx_data_last);

/* fic_modem_model.sv */
`timescale 1ns/100ps
// modem stand-in: symbols sent are played back as received
module fic_modem_model (
    input wire logic clk,
    input wire logic flush,
    input wire logic stall,
    input wire logic tx_sym,
    input wire logic tx_sym_valid,
    output logic tx_sym_ready,
    output logic rx_sym = 1'b1,
    output logic rx_sym_valid = 1'b0,
    input wire logic rx_sym_ready
);
    logic sym_q[$]; // symbols waiting for playback
    logic last_reg = 1'b0; // last symbol played
    logic take_tx, take_rx, sym_in, fl;
    assign tx_sym_ready = !stall;
    // sample at the edge, update just after; an idle line shows the inverse of its last symbol
    always @(posedge clk) begin
        take_tx = tx_sym_valid && tx_sym_ready;
        take_rx = rx_sym_valid && rx_sym_ready;
        sym_in = tx_sym;
        fl = flush;
        #1;
        if (take_rx) last_reg = sym_q.pop_front();
        if (take_tx) sym_q.push_back(sym_in);
        if (fl) sym_q.delete();
        rx_sym_valid = sym_q.size() != 0;
        rx_sym = rx_sym_valid ? sym_q[0] : !last_reg;
    end
endmodule

/* fic_interleave_codec_test.sv */
`timescale 1ns/100ps
// loopback bench: packets go out through the modem model and come back
module fic_interleave_codec_test
    import fic_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, modem_cfg_correction_enable = 1'b0;
    logic tx_valid = 1'b0, tx_last = 1'b0, rx_start = 1'b0, flush = 1'b0, stall = 1'b0;
    logic [7:0] tx_data = 8'h00, rx_len = 8'h00, rx_data;
    logic tx_ready, tx_sym, tx_sym_valid, tx_sym_ready, rx_sym, rx_sym_valid, rx_sym_ready;
    logic rx_data_valid, rx_data_last;
    logic exp_sym[$];
    logic [8:0] exp_rx[$];
    logic [31:0] seed = 32'h84E4;
    int n_mismatch = 0, n_tests = 0;
    always #2 clk = ~clk;
    fic_interleave_codec u_dut (.clk, .reset_n, .modem_cfg_correction_enable, .tx_data, .tx_valid, .tx_last,
        .tx_ready, .tx_sym, .tx_sym_valid, .tx_sym_ready, .rx_start, .rx_len, .rx_sym, .rx_sym_valid,
        .rx_sym_ready, .rx_data, .rx_data_valid, .rx_data_last);
    fic_modem_model u_modem (.clk, .flush, .stall, .tx_sym, .tx_sym_valid, .tx_sym_ready, .rx_sym,
        .rx_sym_valid, .rx_sym_ready);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // compare results with the oldest notes, then pick the next stall
    always @(posedge clk) begin
        if (tx_sym_valid && tx_sym_ready) check("tx_sym", tx_sym, exp_sym.size() ? exp_sym.pop_front() : 'x);
        if (rx_data_valid) check("rx", {rx_data_last, rx_data}, exp_rx.size() ? exp_rx.pop_front() : 'x);
        #1 seed = xs(seed);
        stall = seed[1] & seed[0];
    end
    task automatic packet(input logic en, input int len, input bit hit);
        logic [7:0] b[$];
        logic [3:0] w;
        int m, k;
        flush = 1'b1;
        modem_cfg_correction_enable = en;
        w = 4'h0;
        for (int i = 0; i < len; i++) begin
            seed = xs(seed);
            b.push_back(seed[15:8]);
            exp_rx.push_back({i == len - 1, seed[15:8]});
        end
        // coded: rows filled, columns read, pad to even, pair from four-bit window
        for (int i = 0; i < (en ? (len + 2 - len % 2) * 8 : len * 8); i++) begin
            m = en ? i % 4 * 4 + i % 16 / 4 : i % 8;
            k = en ? i / 16 * 2 + m / 8 : i / 8;
            w = {w[2:0], k < len ? b[k][7 - m % 8] : 1'b0};
            if (en) exp_sym.push_back(^(w & FIC_POLY_A));
            exp_sym.push_back(en ? ^(w & FIC_POLY_B) : w[0]);
        end
        @(posedge clk);
        #1 flush = 1'b0;
        foreach (b[i]) begin
            tx_data = b[i];
            tx_last = i == len - 1;
            tx_valid = 1'b1;
            do @(posedge clk); while (tx_ready !== 1'b1);
            #1;
        end
        tx_valid = 1'b0;
        for (int i = 0; i < 3000 && exp_sym.size(); i++) @(posedge clk);
        repeat (40) @(posedge clk);
        #1;
        if (hit) u_modem.sym_q[5] = !u_modem.sym_q[5];
        rx_len = len[7:0];
        rx_start = 1'b1;
        @(posedge clk);
        #1 rx_start = 1'b0;
        for (int i = 0; i < 3000 && exp_rx.size(); i++) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        packet(1'b0, 1, 1'b0);
        packet(1'b1, 2, 1'b0);
        packet(1'b1, 3, 1'b1);
        packet(1'b1, 4, 1'b0);
        packet(1'b0, 3, 1'b0);
        check("left", exp_sym.size() + exp_rx.size(), 0);
        conclude();
    end
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule
